// File: hdl/ddr_dev_pkg.sv
// constants, carriers and command codes of the DDR device command interface
package ddr_dev_pkg;
   localparam int BANKS = 4;
   localparam int BA_W = 2;
   localparam int ADDR_W = 13;
   localparam int COL_W = 11;
   localparam int DQ_W = 8;
   localparam int AP_BIT = 10;
   localparam int COL_HI_BIT = 11;
   localparam int BL_LSB = 0;
   localparam int BT_BIT = 3;
   localparam int CL_LSB = 4;
   localparam int DLL_OFF_BIT = 0;
   localparam int PRE_CK = 3;

   localparam logic [BA_W-1:0] MR_BA = 2'h0;
   localparam logic [BA_W-1:0] EMR_BA = 2'h1;

   localparam logic [2:0] BL2_CODE = 3'h1;
   localparam logic [2:0] BL4_CODE = 3'h2;
   localparam logic [2:0] BL8_CODE = 3'h3;
   localparam logic [3:0] BL2_BEATS = 4'h2;
   localparam logic [3:0] BL4_BEATS = 4'h4;
   localparam logic [3:0] BL8_BEATS = 4'h8;
   localparam logic [2:0] BL2_MASK = 3'h1;
   localparam logic [2:0] BL4_MASK = 3'h3;
   localparam logic [2:0] BL8_MASK = 3'h7;

   localparam logic [2:0] CL2_CODE = 3'h2;
   localparam logic [2:0] CL25_CODE = 3'h6;
   localparam logic [2:0] CL3_CODE = 3'h3;
   localparam logic [3:0] CL2_HALF = 4'h4;
   localparam logic [3:0] CL25_HALF = 4'h5;
   localparam logic [3:0] CL3_HALF = 4'h6;

   // command codes as {cs_n, ras_n, cas_n, we_n}
   localparam logic [3:0] CODE_MRS = 4'h0;
   localparam logic [3:0] CODE_REF = 4'h1;
   localparam logic [3:0] CODE_CLOSE = 4'h2;
   localparam logic [3:0] CODE_OPEN = 4'h3;
   localparam logic [3:0] CODE_WR = 4'h4;
   localparam logic [3:0] CODE_RD = 4'h5;

   typedef enum logic [2:0] {
      CMD_NOP, CMD_OPEN, CMD_CLOSE, CMD_RD, CMD_WR, CMD_REF, CMD_MRS
   } cmd_t;

   typedef struct packed {
      logic cke;
      logic cs_n;
      logic ras_n;
      logic cas_n;
      logic we_n;
      logic [BA_W-1:0] ba;
      logic [ADDR_W-1:0] addr;
      logic dm;
      logic [DQ_W-1:0] dq;
   } pins_t;

   typedef struct packed {
      logic [2:0] bl;
      logic interleave;
      logic [2:0] cl;
      logic dll_on;
   } mode_t;

   localparam mode_t MODE_RST = '{bl: BL2_CODE, interleave: 1'b0, cl: CL2_CODE,
                                  dll_on: 1'b1};
endpackage : ddr_dev_pkg

// File: hdl/bank_tracker.sv
// one bank's idle, active and self-timed precharge state
`timescale 1ns/1ps
module bank_tracker #(
   parameter int PRE_CK = ddr_dev_pkg::PRE_CK
) (
   input logic sys_clk,
   input logic resetn,
   input logic tick,
   input logic open,
   input logic close,
   output logic active,
   output logic busy
);
   localparam int CW = $clog2(PRE_CK + 1);
   localparam logic [CW-1:0] PRE_LAST = CW'(PRE_CK - 1);

   typedef enum logic [1:0] {B_IDLE, B_ACTIVE, B_PRE} bank_st_t;
   bank_st_t st_reg, st_next;
   logic [CW-1:0] cnt_reg, cnt_next;

   always_comb begin
      st_next = st_reg;
      cnt_next = cnt_reg;
      unique case (st_reg)
         B_IDLE: if (open) st_next = B_ACTIVE;
         B_ACTIVE: if (close) begin
            st_next = B_PRE;
            cnt_next = PRE_LAST;
         end
         B_PRE: if (tick) begin
            // precharge time counts in device clock cycles, frozen while suspended
            if (cnt_reg == '0) st_next = B_IDLE;
            else cnt_next = cnt_reg - 1'b1;
         end
      endcase
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         st_reg <= B_IDLE;
         cnt_reg <= '0;
      end else begin
         st_reg <= st_next;
         cnt_reg <= cnt_next;
      end
   end

   assign active = (st_reg == B_ACTIVE);
   assign busy = (st_reg == B_PRE);
endmodule : bank_tracker

// File: hdl/ddr_sdram_command_interface.sv
// device-side command decoder, bank control and data burst engine of a DDR DRAM
`timescale 1ns/1ps
module ddr_sdram_command_interface #(
   parameter int MEM_AW = 10,
   parameter int PRE_CK = ddr_dev_pkg::PRE_CK
) (
   input logic sys_clk,
   input logic resetn,
   input logic ck,
   input logic ck_n,
   input ddr_dev_pkg::pins_t pins,
   input logic dqs_in,
   output logic [ddr_dev_pkg::DQ_W-1:0] dq_out,
   output logic dq_oe,
   output logic dqs_out,
   output logic dqs_oe,
   output logic [ddr_dev_pkg::BANKS-1:0] bank_active,
   output ddr_dev_pkg::mode_t mode,
   output logic power_down,
   output logic self_refresh,
   output logic clock_suspended,
   output logic refresh_pulse
);
   localparam int DQ_W = ddr_dev_pkg::DQ_W;
   localparam int COL_W = ddr_dev_pkg::COL_W;
   localparam int BANKS = ddr_dev_pkg::BANKS;
   localparam int CIX_W = MEM_AW - ddr_dev_pkg::BA_W;

   // ---- pin synchronisers: every pin passes two flops
   ddr_dev_pkg::pins_t pins_s1, pins_s2;
   logic ck_s1, ck_s2, ck_d;
   logic ckn_s1, ckn_s2;
   logic dqs_s1, dqs_s2, dqs_d;

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         pins_s1 <= '0;
         pins_s2 <= '0;
         ck_s1 <= 1'b0;
         ck_s2 <= 1'b0;
         ck_d <= 1'b0;
         ckn_s1 <= 1'b1;
         ckn_s2 <= 1'b1;
         dqs_s1 <= 1'b0;
         dqs_s2 <= 1'b0;
         dqs_d <= 1'b0;
      end else begin
         pins_s1 <= pins;
         pins_s2 <= pins_s1;
         ck_s1 <= ck;
         ck_s2 <= ck_s1;
         ck_d <= ck_s2;
         ckn_s1 <= ck_n;
         ckn_s2 <= ckn_s1;
         dqs_s1 <= dqs_in;
         dqs_s2 <= dqs_s1;
         dqs_d <= dqs_s2;
      end
   end

   // pins and clocks share the same two-flop delay, so pins_s2 is the value
   // that stood around the crossing
   logic ck_rise, ck_fall, dqs_edge, half_tick, run_tick;
   assign ck_rise = ck_s2 & ~ck_d & ~ckn_s2;
   assign ck_fall = ~ck_s2 & ck_d;
   assign dqs_edge = dqs_s2 ^ dqs_d;

   // ---- state
   typedef enum logic [1:0] {PWR_ON, PWR_DOWN, PWR_SELF} pwr_t;
   typedef enum logic [1:0] {ACC_IDLE, ACC_RD_WAIT, ACC_RD, ACC_WR} acc_t;

   logic run_reg, run_next;
   pwr_t pwr_reg, pwr_next;
   ddr_dev_pkg::mode_t mode_reg, mode_next;
   logic ref_reg, ref_next;

   acc_t acc_reg, acc_next;
   logic [ddr_dev_pkg::BA_W-1:0] bank_reg, bank_next;
   logic [COL_W-1:0] col_reg, col_next;
   logic [3:0] beat_reg, beat_next;
   logic [3:0] wait_reg, wait_next;
   logic ap_reg, ap_next;
   logic [DQ_W-1:0] dq_reg, dq_next;
   logic dq_oe_reg, dq_oe_next;
   logic dqs_reg, dqs_next;
   logic auto_close, wr_en;

   // the clock edge that samples enable low still runs; freezing starts after it
   assign half_tick = (ck_rise | ck_fall) & run_reg;
   assign run_tick = ck_rise & run_reg;

   // ---- helpers
   function automatic logic [3:0] lat_half(input logic [2:0] c);
      case (c)
         ddr_dev_pkg::CL25_CODE: lat_half = ddr_dev_pkg::CL25_HALF;
         ddr_dev_pkg::CL3_CODE: lat_half = ddr_dev_pkg::CL3_HALF;
         default: lat_half = ddr_dev_pkg::CL2_HALF;
      endcase
   endfunction : lat_half

   function automatic logic [3:0] bl_beats(input logic [2:0] c);
      case (c)
         ddr_dev_pkg::BL4_CODE: bl_beats = ddr_dev_pkg::BL4_BEATS;
         ddr_dev_pkg::BL8_CODE: bl_beats = ddr_dev_pkg::BL8_BEATS;
         default: bl_beats = ddr_dev_pkg::BL2_BEATS;
      endcase
   endfunction : bl_beats

   function automatic logic [COL_W-1:0] burst_col(input logic [COL_W-1:0] base,
                                                  input logic [2:0] i,
                                                  input logic [2:0] bl,
                                                  input logic il);
      logic [2:0] m;
      logic [2:0] lo;
      case (bl)
         ddr_dev_pkg::BL4_CODE: m = ddr_dev_pkg::BL4_MASK;
         ddr_dev_pkg::BL8_CODE: m = ddr_dev_pkg::BL8_MASK;
         default: m = ddr_dev_pkg::BL2_MASK;
      endcase
      // wrap stays inside the burst-aligned block
      lo = il ? (base[2:0] ^ i) : 3'(base[2:0] + i);
      burst_col = {base[COL_W-1:3], (base[2:0] & ~m) | (lo & m)};
   endfunction : burst_col

   // ---- command decode
   ddr_dev_pkg::cmd_t cmd;
   logic [3:0] code;
   assign code = {pins_s2.cs_n, pins_s2.ras_n, pins_s2.cas_n, pins_s2.we_n};

   always_comb begin
      cmd = ddr_dev_pkg::CMD_NOP;
      // chip select high leaves every code unmatched
      if (run_tick) begin
         case (code)
            ddr_dev_pkg::CODE_OPEN: cmd = ddr_dev_pkg::CMD_OPEN;
            ddr_dev_pkg::CODE_CLOSE: cmd = ddr_dev_pkg::CMD_CLOSE;
            ddr_dev_pkg::CODE_RD: cmd = ddr_dev_pkg::CMD_RD;
            ddr_dev_pkg::CODE_WR: cmd = ddr_dev_pkg::CMD_WR;
            ddr_dev_pkg::CODE_REF: cmd = ddr_dev_pkg::CMD_REF;
            ddr_dev_pkg::CODE_MRS: cmd = ddr_dev_pkg::CMD_MRS;
            default: cmd = ddr_dev_pkg::CMD_NOP;
         endcase
      end
   end

   // ---- banks
   logic [BANKS-1:0] bank_busy;

   genvar b;
   generate
      for (b = 0; b < BANKS; b++) begin : g_bank
         logic hit;
         assign hit = (pins_s2.ba == ddr_dev_pkg::BA_W'(b));
         bank_tracker #(
            .PRE_CK(PRE_CK)
         ) u_bank (
            .sys_clk(sys_clk),
            .resetn(resetn),
            .tick(run_tick),
            .open((cmd == ddr_dev_pkg::CMD_OPEN) && hit),
            .close(((cmd == ddr_dev_pkg::CMD_CLOSE) && hit) ||
                   (auto_close && (bank_reg == ddr_dev_pkg::BA_W'(b)))),
            .active(bank_active[b]),
            .busy(bank_busy[b])
         );
      end
   endgenerate

   logic all_idle;
   assign all_idle = ~|bank_active && ~|bank_busy && (acc_reg == ACC_IDLE) &&
                     ((cmd == ddr_dev_pkg::CMD_NOP) || (cmd == ddr_dev_pkg::CMD_REF));

   // ---- clock enable, power modes and mode registers
   always_comb begin
      run_next = run_reg;
      pwr_next = pwr_reg;
      mode_next = mode_reg;
      ref_next = 1'b0;
      if (ck_rise) begin
         run_next = pins_s2.cke;
         unique case (pwr_reg)
            PWR_ON: if (!pins_s2.cke && run_reg && all_idle) begin
               pwr_next = (cmd == ddr_dev_pkg::CMD_REF) ? PWR_SELF : PWR_DOWN;
            end
            PWR_DOWN, PWR_SELF: if (pins_s2.cke) pwr_next = PWR_ON;
         endcase
      end
      if (cmd == ddr_dev_pkg::CMD_REF) ref_next = pins_s2.cke;
      if (cmd == ddr_dev_pkg::CMD_MRS) begin
         if (pins_s2.ba == ddr_dev_pkg::MR_BA) begin
            mode_next.bl = pins_s2.addr[ddr_dev_pkg::BL_LSB +: 3];
            mode_next.interleave = pins_s2.addr[ddr_dev_pkg::BT_BIT];
            mode_next.cl = pins_s2.addr[ddr_dev_pkg::CL_LSB +: 3];
         end else if (pins_s2.ba == ddr_dev_pkg::EMR_BA) begin
            // extended_mode_register_set
            mode_next.dll_on = ~pins_s2.addr[ddr_dev_pkg::DLL_OFF_BIT];
         end
      end
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         run_reg <= 1'b0;
         pwr_reg <= PWR_ON;
         mode_reg <= ddr_dev_pkg::MODE_RST;
         ref_reg <= 1'b0;
      end else begin
         run_reg <= run_next;
         pwr_reg <= pwr_next;
         mode_reg <= mode_next;
         ref_reg <= ref_next;
      end
   end

   // ---- data array: a window of each bank, indexed by bank and low column bits
   logic [DQ_W-1:0] mem [0:(2**MEM_AW)-1];
   logic [COL_W-1:0] beat_col;
   logic [MEM_AW-1:0] mem_idx;
   logic [3:0] beats;

   assign beats = bl_beats(mode_reg.bl);
   assign beat_col = burst_col(col_reg, beat_reg[2:0], mode_reg.bl, mode_reg.interleave);
   assign mem_idx = {bank_reg, beat_col[CIX_W-1:0]};

   always_ff @(posedge sys_clk) begin
      if (wr_en) mem[mem_idx] <= pins_s2.dq;
   end

   // ---- burst engine
   always_comb begin
      acc_next = acc_reg;
      bank_next = bank_reg;
      col_next = col_reg;
      beat_next = beat_reg;
      wait_next = wait_reg;
      ap_next = ap_reg;
      dq_next = dq_reg;
      dq_oe_next = dq_oe_reg;
      dqs_next = dqs_reg;
      auto_close = 1'b0;
      wr_en = 1'b0;
      unique case (acc_reg)
         ACC_IDLE: begin
            if ((cmd == ddr_dev_pkg::CMD_RD) || (cmd == ddr_dev_pkg::CMD_WR)) begin
               bank_next = pins_s2.ba;
               col_next = {pins_s2.addr[ddr_dev_pkg::COL_HI_BIT],
                           pins_s2.addr[9:0]};
               ap_next = pins_s2.addr[ddr_dev_pkg::AP_BIT];
               beat_next = '0;
               wait_next = lat_half(mode_reg.cl);
               acc_next = (cmd == ddr_dev_pkg::CMD_RD) ? ACC_RD_WAIT : ACC_WR;
            end
         end
         ACC_RD_WAIT: begin
            if (half_tick) begin
               if (wait_reg == 4'h1) begin
                  dq_next = mem[mem_idx];
                  dqs_next = 1'b1;
                  dq_oe_next = 1'b1;
                  beat_next = beat_reg + 4'h1;
                  acc_next = ACC_RD;
               end else begin
                  wait_next = wait_reg - 4'h1;
               end
            end
         end
         ACC_RD: begin
            // burst address holds while the clock is suspended
            if (half_tick) begin
               if (beat_reg == beats) begin
                  dq_oe_next = 1'b0;
                  dqs_next = 1'b0;
                  acc_next = ACC_IDLE;
                  auto_close = ap_reg;
               end else begin
                  dq_next = mem[mem_idx];
                  dqs_next = ~dqs_reg;
                  beat_next = beat_reg + 4'h1;
               end
            end
         end
         ACC_WR: begin
            if (dqs_edge) begin
               wr_en = ~pins_s2.dm;
               beat_next = beat_reg + 4'h1;
               if (beat_reg == beats - 4'h1) begin
                  acc_next = ACC_IDLE;
                  auto_close = ap_reg;
               end
            end
         end
      endcase
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         acc_reg <= ACC_IDLE;
         bank_reg <= '0;
         col_reg <= '0;
         beat_reg <= '0;
         wait_reg <= '0;
         ap_reg <= 1'b0;
         dq_reg <= '0;
         dq_oe_reg <= 1'b0;
         dqs_reg <= 1'b0;
      end else begin
         acc_reg <= acc_next;
         bank_reg <= bank_next;
         col_reg <= col_next;
         beat_reg <= beat_next;
         wait_reg <= wait_next;
         ap_reg <= ap_next;
         dq_reg <= dq_next;
         dq_oe_reg <= dq_oe_next;
         dqs_reg <= dqs_next;
      end
   end

   // ---- outputs
   assign dq_out = dq_reg;
   assign dq_oe = dq_oe_reg;
   assign dqs_out = dqs_reg;
   assign dqs_oe = dq_oe_reg;
   assign mode = mode_reg;
   assign power_down = (pwr_reg == PWR_DOWN);
   assign self_refresh = (pwr_reg == PWR_SELF);
   assign clock_suspended = ~run_reg && (pwr_reg == PWR_ON);
   assign refresh_pulse = ref_reg;
endmodule : ddr_sdram_command_interface

// File: sim/ddr_sdram_command_interface_asserts.sv
// port assertions for the DDR device command interface
`timescale 1ns/1ps
module ddr_sdram_command_interface_asserts (
   input logic sys_clk,
   input logic resetn,
   input logic ck,
   input logic ck_n,
   input ddr_dev_pkg::pins_t pins,
   input logic [7:0] dq_out,
   input logic dq_oe,
   input logic dqs_out,
   input logic dqs_oe,
   input logic [3:0] bank_active,
   input ddr_dev_pkg::mode_t mode,
   input logic power_down,
   input logic self_refresh,
   input logic clock_suspended,
   input logic refresh_pulse
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!resetn);
   logic [7:0] oe_cnt_reg;
   logic [7:0] oe_cnt_next;
   logic [7:0] burst_cyc;
   logic [3:0] code;
   // one beat lasts one ck half cycle, eight sys_clk at bench rates
   always_comb begin
      oe_cnt_next = dq_oe ? oe_cnt_reg + 8'h01 : 8'h00;
      burst_cyc = (mode.bl == ddr_dev_pkg::BL8_CODE) ? 8'h40 :
                  (mode.bl == ddr_dev_pkg::BL4_CODE) ? 8'h20 : 8'h10;
      code = {pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n};
   end
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         oe_cnt_reg <= 8'h00;
      end else begin
         oe_cnt_reg <= oe_cnt_next;
      end
   end
   AST_RESET_STATE: assert property ($rose(resetn) |->
      mode == ddr_dev_pkg::MODE_RST && bank_active == 4'h0 && !dq_oe)
      else $error("state after reset wrong");
   AST_OPEN_DECODE: assert property ((bank_active & ~$past(bank_active)) != 4'h0 |->
      ck && !ck_n && code == ddr_dev_pkg::CODE_OPEN && bank_active[pins.ba])
      else $error("bank opened without open command");
   AST_MODE_DECODE: assert property (mode != $past(mode) |->
      ck && !ck_n && code == ddr_dev_pkg::CODE_MRS)
      else $error("mode changed without mode set");
   AST_BURST_LEN: assert property ($fell(dq_oe) |->
      oe_cnt_reg >= burst_cyc - 8'h01 && oe_cnt_reg <= burst_cyc + 8'h01)
      else $error("read burst length wrong");
   AST_DQS_OE: assert property (dqs_oe == dq_oe && (!$rose(dqs_oe) || dqs_out))
      else $error("strobe enable differs from data enable");
   AST_DQS_START: assert property ($rose(dq_oe) |-> dqs_out ##[7:9] !dqs_out)
      else $error("read strobe not edge aligned");
   AST_DQS_IDLE: assert property (!dq_oe |-> !dqs_out)
      else $error("strobe high outside burst");
   AST_POWER_IDLE: assert property ($rose(power_down) || $rose(self_refresh) |->
      $past(bank_active) == 4'h0 && !dq_oe)
      else $error("power mode entered with bank busy");
   AST_SUSPEND_FREEZE: assert property (clock_suspended && $past(clock_suspended, 3) |->
      $stable(dq_out) && $stable(dqs_out))
      else $error("outputs moved while suspended");
   AST_MODES_EXCL: assert property (!(power_down && self_refresh) &&
      !(clock_suspended && (power_down || self_refresh)))
      else $error("power states overlap");
   COV_READ: cover property ($rose(dq_oe));
   COV_PD: cover property ($rose(power_down));
   COV_SR: cover property ($rose(self_refresh));
   COV_REF: cover property (refresh_pulse);
endmodule : ddr_sdram_command_interface_asserts

// File: sim/ddr_host_model.sv
// host controller model: free differential clock, command and write strobe driver
`timescale 1ns/1ps
module ddr_host_model (
   output logic ck,
   output logic ck_n,
   output ddr_dev_pkg::pins_t pins,
   output logic dqs_in
);
   time t_rise;
   initial begin
      ck = 1'b0;
      ck_n = 1'b1;
      dqs_in = 1'b0;
      pins = '0;
      pins.cs_n = 1'b1;
      forever begin
         #32 ck = ~ck;
         ck_n = ~ck;
      end
   end
   // pins settle half a ck cycle before the rise and hold half a cycle after
   task automatic cmd(input logic [3:0] c, input logic [1:0] b, input logic [12:0] a,
                      input logic e);
      @(negedge ck);
      pins.cke = e;
      {pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n} = c;
      pins.ba = b;
      pins.addr = a;
      @(posedge ck);
      t_rise = $time;
      @(negedge ck);
      pins.cs_n = 1'b1;
      pins.ba = ~b;
      pins.addr = ~a;
   endtask : cmd
   // strobe edge sits mid-beat so data is stable on both sides of it
   task automatic wr_beats(input logic [7:0] d [8], input logic m [8], input int n);
      for (int i = 0; i < n; i++) begin
         pins.dq = d[i];
         pins.dm = m[i];
         #16 dqs_in = ~dqs_in;
         #16;
      end
      pins.dq = ~pins.dq;
      pins.dm = ~pins.dm;
   endtask : wr_beats
endmodule : ddr_host_model

// File: sim/ddr_sdram_command_interface_tb_top.sv
// self-checking bench for the DDR device command interface
`timescale 1ns/1ps
module ddr_sdram_command_interface_tb_top;
   localparam logic [3:0] nop_code = 4'h7;
   logic sys_clk, resetn, ck, ck_n, dqs_in, dq_oe, dqs_out, dqs_oe, prev, il;
   logic power_down, self_refresh, clock_suspended, refresh_pulse;
   logic [7:0] dq_out;
   logic [3:0] bank_active;
   logic [2:0] bl;
   logic [2:0] cls [3];
   logic [3:0] halves [3];
   ddr_dev_pkg::pins_t pins;
   ddr_dev_pkg::mode_t mode;
   int n_mismatch, tests_run, seed, n_ref, w, k, i, j, n, base;
   logic [7:0] mem [int];
   logic [7:0] d [8];
   logic m [8];
   wire [2:0] pstate = {self_refresh, power_down, clock_suspended};
   ddr_sdram_command_interface #(.PRE_CK(1)) i_dut (.sys_clk(sys_clk), .resetn(resetn),
      .ck(ck), .ck_n(ck_n), .pins(pins), .dqs_in(dqs_in), .dq_out(dq_out), .dq_oe(dq_oe),
      .dqs_out(dqs_out), .dqs_oe(dqs_oe), .bank_active(bank_active), .mode(mode),
      .power_down(power_down), .self_refresh(self_refresh),
      .clock_suspended(clock_suspended), .refresh_pulse(refresh_pulse));
   ddr_host_model i_host (.ck(ck), .ck_n(ck_n), .pins(pins), .dqs_in(dqs_in));
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      tests_run++;
      if (got !== exp) begin
         n_mismatch++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic summarize();
      $display("mismatches %0d comparisons %0d", n_mismatch, tests_run);
      if (n_mismatch == 0 && tests_run > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : summarize
   task automatic hang(input string what);
      n_mismatch++;
      $display("ERROR %s expected done seen timeout", what);
      summarize();
   endtask : hang
   initial begin
      sys_clk = 1'b0;
      forever #2 sys_clk = ~sys_clk;
   end
   // counted on the falling edge, half a cycle from the launching edge, so the one-cycle pulse is seen exactly once
   always @(negedge sys_clk) if (refresh_pulse === 1'b1) n_ref++;
   initial begin
      resetn = 1'b0;
      seed = 32'h8D12;
      n_mismatch = 0;
      tests_run = 0;
      n_ref = 0;
      cls = '{ddr_dev_pkg::CL2_CODE, ddr_dev_pkg::CL25_CODE, ddr_dev_pkg::CL3_CODE};
      halves = '{ddr_dev_pkg::CL2_HALF, ddr_dev_pkg::CL25_HALF, ddr_dev_pkg::CL3_HALF};
      repeat (6) @(negedge sys_clk);
      resetn = 1'b1;
      chk("mode", ddr_dev_pkg::MODE_RST, mode);
      chk("bank_active", 8'h00, bank_active);
      $display("test reset done");
      i_host.cmd(nop_code, 2'h0, 13'h0000, 1'b1);
      i_host.cmd(ddr_dev_pkg::CODE_MRS, ddr_dev_pkg::MR_BA, 13'h0023, 1'b1);
      i_host.cmd(ddr_dev_pkg::CODE_OPEN, 2'h1, 13'($random(seed)), 1'b1);
      chk("bank_active", 8'h02, bank_active);
      // aligned eight-beat writes land the same whatever the burst order
      for (k = 0; k < 4; k++) begin
         for (i = 0; i < 8; i++) begin
            d[i] = 8'($random(seed));
            m[i] = (k > 1) ? 1'($random(seed)) : 1'b0;
            if (m[i] !== 1'b1) mem[(k % 2) * 8 + i] = d[i];
         end
         i_host.cmd(ddr_dev_pkg::CODE_WR, 2'h1, 13'((k % 2) * 8), 1'b1);
         i_host.wr_beats(d, m, 8);
      end
      $display("test write done");
      for (k = 0; k < 6; k++) begin
         bl = 3'(k % 3 + 1);
         n = 2 << (k % 3);
         il = 1'(k % 2);
         base = $random(seed) & 15;
         i_host.cmd(ddr_dev_pkg::CODE_MRS, ddr_dev_pkg::MR_BA,
                    {6'h00, cls[(k + 1) / 2 % 3], il, bl}, 1'b1);
         i_host.cmd(ddr_dev_pkg::CODE_OPEN, 2'h1, 13'h0ABC, 1'b1);
         i_host.cmd(ddr_dev_pkg::CODE_RD, 2'h1, 13'(base) | 13'h0400, 1'b1);
         for (w = 0; w < 200 && dq_oe !== 1'b1; w++) @(negedge sys_clk);
         if (w == 200) hang("read start");
         chk("latency", halves[(k + 1) / 2 % 3], 8'(($time - i_host.t_rise) / 32));
         for (i = 0; i < n; i++) begin
            j = (il ? (base ^ i) : (base + i)) & (n - 1) | (base & ~(n - 1));
            chk("read byte", mem[j], dq_out);
            prev = dqs_out;
            for (w = 0; w < 20 && dqs_out === prev; w++) @(negedge sys_clk);
            if (w == 20 && i < n - 1) hang("read beat");
         end
         for (w = 0; w < 100 && bank_active[1] !== 1'b0; w++) @(negedge sys_clk);
         chk("auto close", 8'h00, bank_active);
      end
      $display("test read done");
      i_host.cmd(ddr_dev_pkg::CODE_OPEN | 4'h8, 2'h2, 13'h0001, 1'b1);
      i_host.cmd(nop_code, 2'h0, 13'h0000, 1'b1);
      chk("masked open", 8'h00, bank_active);
      i_host.cmd(ddr_dev_pkg::CODE_OPEN, 2'h3, 13'h1FFF, 1'b1);
      i_host.cmd(nop_code, 2'h0, 13'h0000, 1'b0);
      chk("power state", 8'h01, pstate);
      i_host.cmd(nop_code, 2'h0, 13'h0000, 1'b1);
      i_host.cmd(ddr_dev_pkg::CODE_CLOSE, 2'h3, 13'h0000, 1'b1);
      chk("bank_active", 8'h00, bank_active);
      i_host.cmd(nop_code, 2'h0, 13'h0000, 1'b1);
      $display("test bank done");
      // all banks idle from here, so cke low must pick a power mode
      for (k = 0; k < 2; k++) begin
         i_host.cmd(k ? ddr_dev_pkg::CODE_REF : nop_code, 2'h0, 13'h0000, 1'b0);
         chk("power state", k ? 8'h04 : 8'h02, pstate);
         i_host.cmd(nop_code, 2'h0, 13'h0000, 1'b1);
         chk("power state", 8'h00, pstate);
      end
      // one refresh stands for the host's evenly spread refresh schedule
      i_host.cmd(ddr_dev_pkg::CODE_REF, 2'h0, 13'h0000, 1'b1);
      chk("refresh count", 8'h01, 8'(n_ref));
      $display("test power done");
      i_host.cmd(ddr_dev_pkg::CODE_MRS, ddr_dev_pkg::EMR_BA, 13'h0001, 1'b1);
      chk("dll", 8'h00, mode.dll_on);
      i_host.cmd(ddr_dev_pkg::CODE_MRS, ddr_dev_pkg::EMR_BA, 13'h0000, 1'b1);
      chk("dll", 8'h01, mode.dll_on);
      $display("test dll done");
      summarize();
   end
endmodule : ddr_sdram_command_interface_tb_top
bind ddr_sdram_command_interface ddr_sdram_command_interface_asserts i_chk (.sys_clk(sys_clk),
   .resetn(resetn), .ck(ck), .ck_n(ck_n), .pins(pins), .dq_out(dq_out), .dq_oe(dq_oe),
   .dqs_out(dqs_out), .dqs_oe(dqs_oe), .bank_active(bank_active), .mode(mode),
   .power_down(power_down), .self_refresh(self_refresh),
   .clock_suspended(clock_suspended), .refresh_pulse(refresh_pulse));
